// ==== rtl/irq_map.svh ====
/*
  register offsets, bit positions, reset values for the timer and pin change irq block.
  assumes a 32-bit apb bus with byte addresses and word-aligned registers.
*/
`ifndef IRQ_MAP_SVH
`define IRQ_MAP_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_INTCTL   12'h000
`define OFS_INTCTL2  12'h004
`define OFS_TMRCTL   12'h008
`define OFS_TMRCNT   12'h00C
`define OFS_SHADOW   12'h010
`define OFS_STACK    12'h014
// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_TOF_IE   5
`define BIT_PC_IE    3
`define BIT_TOF_FLAG 2
`define BIT_PC_FLAG  0
`define BIT_TOF_PRI  2
`define BIT_PC_PRI   0
`define BIT_TMR_RUN  0
`define BIT_TMR_W16  1
// ----------------------------------------
// reset values and wrap points
// ----------------------------------------
`define RST_BYTE     8'h00
`define RST_COUNT    16'h0000
`define MAX8         8'hFF
`define MAX16        16'hFFFF
`endif

// ==== rtl/irq_pkg.sv ====
/*
  types for the timer and pin change irq block.
  assumes nothing of its surroundings.
*/
package irq_pkg;
  typedef enum logic {WIDTH8_T = 1'b0, WIDTH16_T = 1'b1} timer_width_t;
  typedef logic [20:0] pc_addr_t;
  typedef logic [7:0]  byte_t;
endpackage

// ==== rtl/timer_and_pin_change_irq.sv ====
/*
  timer overflow and upper nibble pin change interrupt sources with apb registers,
  return address stack and one-deep fast return shadow.
  assumes the core pulses irq_accept for one cycle when it takes an interrupt and
  ret_pop when it returns; port pins are asynchronous.
*/
// Operation
// (RULE1) 8-bit mode: FFh to 00h sets flag
// (RULE2) 16-bit mode: FFFFh to 0000h sets flag
// (RULE3) timer request passes only when enabled
// (RULE4) timer priority bit routes high or low
// (RULE5) any change on pins 7:4 sets flag
// (RULE6) pin request passes only when enabled
// (RULE7) pin priority bit routes high or low
// (RULE8) accept pushes return address onto stack
// (RULE9) accept copies working, status, bank to shadow
// (RULE10) flags set always, held until software clears
`timescale 1ns/1ns
`default_nettype none
`include "irq_map.svh"
module timer_and_pin_change_irq
  import irq_pkg::*;
#(
  parameter int STACK_DEPTH = 31
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [3:0]  upper_nibble_input_port,
  input  wire logic        irq_accept,
  input  wire logic        ret_pop,
  input  wire pc_addr_t    program_counter,
  input  wire byte_t       working_accumulator,
  input  wire byte_t       status_value,
  input  wire byte_t       bank_select_reg,
  output logic             irq_high,
  output logic             irq_low,
  output pc_addr_t         return_addr,
  output byte_t            shadow_working,
  output byte_t            shadow_status,
  output byte_t            shadow_bank
);
  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  generate
    if (STACK_DEPTH < 2 || STACK_DEPTH > 31) begin : bad_depth
      $error("STACK_DEPTH must lie in 2..31");
    end
  endgenerate

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  logic        pready_ff, pslverr_ff;
  logic [31:0] prdata_ff, nxt_rdata;
  logic        nxt_unmapped;
  logic        tof_flag_ff, pc_flag_ff, tof_ie_ff, pc_ie_ff, tof_pri_ff, pc_pri_ff;
  logic        run_ff;
  timer_width_t width_ff;
  logic [15:0] count_ff;
  logic [4:0]  sp_ff;
  wire         setup  = psel & ~penable;
  wire         wr_go  = psel & penable & pready_ff & pwrite;
  wire         wr_ctl = wr_go & (paddr == `OFS_INTCTL);

  // read mux and decode
  always_comb begin
    nxt_rdata    = 32'h0000_0000;
    nxt_unmapped = 1'b0;
    case (paddr)
      `OFS_INTCTL: begin
        nxt_rdata[`BIT_TOF_IE]   = tof_ie_ff;
        nxt_rdata[`BIT_PC_IE]    = pc_ie_ff;
        nxt_rdata[`BIT_TOF_FLAG] = tof_flag_ff;
        nxt_rdata[`BIT_PC_FLAG]  = pc_flag_ff;
      end
      `OFS_INTCTL2: begin
        nxt_rdata[`BIT_TOF_PRI] = tof_pri_ff;
        nxt_rdata[`BIT_PC_PRI]  = pc_pri_ff;
      end
      `OFS_TMRCTL: begin
        nxt_rdata[`BIT_TMR_RUN] = run_ff;
        nxt_rdata[`BIT_TMR_W16] = width_ff;
      end
      `OFS_TMRCNT: nxt_rdata[15:0] = count_ff;
      `OFS_SHADOW: nxt_rdata[23:0] = {shadow_bank, shadow_status, shadow_working};
      `OFS_STACK:  nxt_rdata = {6'h00, sp_ff, return_addr};
      default:     nxt_unmapped = 1'b1;
    endcase
  end

  // zero-wait answer in the first access cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup & nxt_unmapped;
      prdata_ff  <= (setup & ~pwrite) ? nxt_rdata : 32'h0000_0000;
    end
  end
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign prdata  = prdata_ff;

  // ----------------------------------------
  // control and priority bits
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tof_ie_ff  <= 1'b0;
      pc_ie_ff   <= 1'b0;
      tof_pri_ff <= 1'b1;
      pc_pri_ff  <= 1'b1;
      run_ff     <= 1'b0;
      width_ff   <= WIDTH8_T;
    end else begin
      if (wr_ctl) begin
        tof_ie_ff <= pwdata[`BIT_TOF_IE];
        pc_ie_ff  <= pwdata[`BIT_PC_IE];
      end
      if (wr_go && paddr == `OFS_INTCTL2) begin
        tof_pri_ff <= pwdata[`BIT_TOF_PRI];
        pc_pri_ff  <= pwdata[`BIT_PC_PRI];
      end
      if (wr_go && paddr == `OFS_TMRCTL) begin
        run_ff   <= pwdata[`BIT_TMR_RUN];
        width_ff <= timer_width_t'(pwdata[`BIT_TMR_W16]);
      end
    end
  end

  // ----------------------------------------
  // timer and overflow detection
  // ----------------------------------------
  wire wrap8  = run_ff & (width_ff == WIDTH8_T) & (count_ff[7:0] == `MAX8);
  wire wrap16 = run_ff & (width_ff == WIDTH16_T) & (count_ff == `MAX16);
  wire tof_ev = ~(wr_go & (paddr == `OFS_TMRCNT)) & (wrap8 | wrap16);

  // count; a software load wins over the increment
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_ff <= `RST_COUNT;
    end else if (wr_go && paddr == `OFS_TMRCNT) begin
      count_ff <= pwdata[15:0];
    end else if (run_ff) begin
      count_ff <= count_ff + 16'h0001;
    end
  end

  // ----------------------------------------
  // pin change detection
  // ----------------------------------------
  logic [3:0] pin_s1_ff, pin_s2_ff, pin_prev_ff;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_s1_ff   <= 4'h0;
      pin_s2_ff   <= 4'h0;
      pin_prev_ff <= 4'h0;
    end else begin
      pin_s1_ff   <= upper_nibble_input_port;
      pin_s2_ff   <= pin_s1_ff;
      pin_prev_ff <= pin_s2_ff;
    end
  end
  wire pc_ev = |(pin_s2_ff ^ pin_prev_ff); // RULE5

  // ----------------------------------------
  // sticky flags: set wins, software writes 0 to clear
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tof_flag_ff <= 1'b0;
      pc_flag_ff  <= 1'b0;
    end else begin
      tof_flag_ff <= tof_ev | (tof_flag_ff & ~(wr_ctl & ~pwdata[`BIT_TOF_FLAG])); // RULE1 RULE2 RULE10
      pc_flag_ff  <= pc_ev | (pc_flag_ff & ~(wr_ctl & ~pwdata[`BIT_PC_FLAG]));    // RULE5 RULE10
    end
  end

  // ----------------------------------------
  // request gating and priority routing
  // ----------------------------------------
  logic irq_high_ff, irq_low_ff;
  wire  tof_req = tof_flag_ff & tof_ie_ff; // RULE3
  wire  pc_req  = pc_flag_ff & pc_ie_ff;   // RULE6
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_high_ff <= 1'b0;
      irq_low_ff  <= 1'b0;
    end else begin
      irq_high_ff <= (tof_req & tof_pri_ff) | (pc_req & pc_pri_ff);   // RULE4 RULE7
      irq_low_ff  <= (tof_req & ~tof_pri_ff) | (pc_req & ~pc_pri_ff); // RULE4 RULE7
    end
  end
  assign irq_high = irq_high_ff;
  assign irq_low  = irq_low_ff;

  // ----------------------------------------
  // return address stack; push ignored when full
  // ----------------------------------------
  pc_addr_t stack_mem [STACK_DEPTH];
  pc_addr_t top_ff;
  wire      push = irq_accept & (sp_ff != 5'(STACK_DEPTH));
  wire      pop  = ~irq_accept & ret_pop & (sp_ff != 5'h00);

  // stack storage
  always_ff @(posedge ref_clk) begin
    if (push) begin
      stack_mem[sp_ff] <= program_counter; // RULE8
    end
  end

  // pointer and top-of-stack copy
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sp_ff  <= 5'h00;
      top_ff <= 21'h000000;
    end else if (push) begin
      sp_ff  <= sp_ff + 5'h01;
      top_ff <= program_counter; // RULE8
    end else if (pop) begin
      sp_ff  <= sp_ff - 5'h01;
      top_ff <= (sp_ff > 5'h01) ? stack_mem[sp_ff - 5'h02] : 21'h000000;
    end
  end
  assign return_addr = top_ff;

  // ----------------------------------------
  // fast return shadow
  // ----------------------------------------
  byte_t sh_w_ff, sh_s_ff, sh_b_ff;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sh_w_ff <= `RST_BYTE;
      sh_s_ff <= `RST_BYTE;
      sh_b_ff <= `RST_BYTE;
    end else if (irq_accept) begin
      sh_w_ff <= working_accumulator; // RULE9
      sh_s_ff <= status_value;        // RULE9
      sh_b_ff <= bank_select_reg;     // RULE9
    end
  end
  assign shadow_working = sh_w_ff;
  assign shadow_status  = sh_s_ff;
  assign shadow_bank    = sh_b_ff;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  wrap8_flag_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE1
    run_ff && width_ff == WIDTH8_T && count_ff[7:0] == 8'hFF && !wr_go |=> tof_flag_ff)
    else $error("8-bit wrap did not set flag");
  wrap16_flag_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE2
    !tof_flag_ff && width_ff == WIDTH16_T && count_ff != 16'hFFFF ##1 !wr_go
    |=> !tof_flag_ff || $past(count_ff, 2) == 16'hFFFF || $past(count_ff) == 16'hFFFF)
    else $error("16-bit flag set without full wrap");
  tof_gate_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE3
    !tof_ie_ff && !pc_flag_ff |=> !irq_high_ff && !irq_low_ff)
    else $error("timer request passed while disabled");
  tof_route_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE4
    tof_req && !pc_req |=> irq_high_ff == $past(tof_pri_ff) && irq_low_ff == !$past(tof_pri_ff))
    else $error("timer priority misrouted");
  pin_flag_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE5
    $changed(pin_s2_ff) ##1 1'b1 |-> pc_flag_ff)
    else $error("pin change did not set flag");
  pin_gate_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE6
    pc_flag_ff && !pc_ie_ff && !tof_req |=> !irq_high_ff && !irq_low_ff)
    else $error("pin request passed while disabled");
  pin_route_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE7
    pc_req && !tof_req |=> irq_high_ff == $past(pc_pri_ff) && irq_low_ff != $past(pc_pri_ff))
    else $error("pin priority misrouted");
  stack_push_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE8
    irq_accept && sp_ff < 5'(STACK_DEPTH)
    |=> sp_ff == $past(sp_ff) + 5'h01 && return_addr == $past(program_counter))
    else $error("return address not pushed");
  shadow_copy_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE9
    irq_accept |=> shadow_working == $past(working_accumulator)
      && shadow_status == $past(status_value) && shadow_bank == $past(bank_select_reg))
    else $error("shadow not captured");
  flag_hold_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE10
    pc_flag_ff && !(wr_ctl && !pwdata[0]) |=> pc_flag_ff)
    else $error("flag dropped without clear");
endmodule
`default_nettype wire

// ==== tb/core_model.sv ====
/*
  core sequencer and upper nibble port pin model for the irq block.
  assumes the bench calls its tasks; signals change just after rising edges.
*/
`timescale 1ns/1ns
`default_nettype none
module core_model
  import irq_pkg::*;
(
  input  wire logic  ref_clk,
  output logic       irq_accept,
  output logic       ret_pop,
  output pc_addr_t   program_counter,
  output byte_t      working_accumulator,
  output byte_t      status_value,
  output byte_t      bank_select_reg,
  output logic [3:0] upper_nibble_input_port
);
  // idle core, pins low
  initial begin
    irq_accept = 1'b0;
    ret_pop = 1'b0;
    {program_counter, working_accumulator, status_value, bank_select_reg} = '0;
    upper_nibble_input_port = 4'h0;
  end
  // one-cycle accept pulse; context scrambled once it is over
  task automatic take(input pc_addr_t pc, input byte_t w, input byte_t s, input byte_t b);
    @(posedge ref_clk);
    irq_accept <= 1'b1;
    {program_counter, working_accumulator, status_value, bank_select_reg} <= {pc, w, s, b};
    @(posedge ref_clk);
    irq_accept <= 1'b0;
    {program_counter, working_accumulator, status_value, bank_select_reg} <= ~{pc, w, s, b};
  endtask
  // return from interrupt
  task automatic pop();
    @(posedge ref_clk);
    ret_pop <= 1'b1;
    @(posedge ref_clk);
    ret_pop <= 1'b0;
  endtask
  // new pin levels
  task automatic set_pins(input logic [3:0] v);
    @(posedge ref_clk);
    upper_nibble_input_port <= v;
  endtask
endmodule
`default_nettype wire

// ==== tb/timer_and_pin_change_irq_bench.sv ====
/*
  self-checking bench for the timer and pin change irq block.
  assumes zero-wait apb answers and the core model beside it.
*/
`timescale 1ns/1ns
`default_nettype none
`include "irq_map.svh"
module timer_and_pin_change_irq_bench import irq_pkg::*;;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        pready, pslverr, irq_accept, ret_pop, irq_high, irq_low;
  logic [31:0] prdata;
  logic [3:0]  upper_nibble_input_port;
  pc_addr_t    program_counter, return_addr;
  byte_t       working_accumulator, status_value, bank_select_reg;
  byte_t       shadow_working, shadow_status, shadow_bank, w, s, b;
  pc_addr_t    pcs[3];
  logic [32:0] exp_q[$];
  int          n_fail = 0;
  int          checks_done = 0;
  // ----------------------------------------
  // design and far side
  // ----------------------------------------
  timer_and_pin_change_irq #(.STACK_DEPTH(31)) u_dut (.ref_clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .upper_nibble_input_port,
    .irq_accept, .ret_pop, .program_counter, .working_accumulator, .status_value,
    .bank_select_reg, .irq_high, .irq_low, .return_addr, .shadow_working,
    .shadow_status, .shadow_bank);
  core_model u_core (.ref_clk, .irq_accept, .ret_pop, .program_counter,
    .working_accumulator, .status_value, .bank_select_reg, .upper_nibble_input_port);
  initial forever #5 ref_clk = ~ref_clk;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (exp_q.size() != 0) n_fail++;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // apb transfer held until pready; reads note the expected answer
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] e);
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    if (!wr) exp_q.push_back(e);
    @(posedge ref_clk);
    penable <= 1'b1;
    // wait for pready; the hang guard ends this wait if pready never rises
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, {1'b0, e});
  endtask
  task automatic lvl(input logic hi, input logic lo);
    check("irq", {31'h0, irq_high, irq_low}, {31'h0, hi, lo});
  endtask
  // compare each read answer with the oldest note
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      check("prdata", {pslverr, prdata}, exp_q.pop_front());
    end
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    wrap_up();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hD497F4E0));
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`OFS_INTCTL, 32'h0);
    rd(`OFS_INTCTL2, 32'h5);
    xfer(1'b0, 12'h018, 32'h0, {1'b1, 32'h0});
    u_core.set_pins(4'($urandom));
    repeat (6) @(posedge ref_clk);
    wr(`OFS_INTCTL, 32'h0);
    // 8-bit wrap with enable off, then on, then low priority
    wr(`OFS_TMRCNT, 32'h00FD);
    wr(`OFS_TMRCTL, 32'h1);
    repeat (6) @(posedge ref_clk);
    lvl(1'b0, 1'b0);
    rd(`OFS_INTCTL, 32'h4);
    rd(`OFS_INTCTL, 32'h4);
    wr(`OFS_INTCTL, 32'h24);
    repeat (2) @(posedge ref_clk);
    lvl(1'b1, 1'b0);
    wr(`OFS_INTCTL2, 32'h1);
    repeat (2) @(posedge ref_clk);
    lvl(1'b0, 1'b1);
    wr(`OFS_TMRCTL, 32'h2);
    wr(`OFS_INTCTL, 32'h0);
    rd(`OFS_INTCTL, 32'h0);
    // 16-bit: low byte wrap alone sets nothing, pair wrap does
    wr(`OFS_TMRCNT, 32'h00FD);
    wr(`OFS_TMRCTL, 32'h3);
    repeat (6) @(posedge ref_clk);
    rd(`OFS_INTCTL, 32'h0);
    wr(`OFS_TMRCTL, 32'h2);
    wr(`OFS_TMRCNT, 32'hFFFD);
    wr(`OFS_TMRCTL, 32'h3);
    repeat (6) @(posedge ref_clk);
    rd(`OFS_INTCTL, 32'h4);
    wr(`OFS_TMRCTL, 32'h0);
    // one pin at a time, alternating priority
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_INTCTL, 32'h08);
      wr(`OFS_INTCTL2, {31'h0, i[0]});
      u_core.set_pins(upper_nibble_input_port ^ (4'h1 << i));
      repeat (6) @(posedge ref_clk);
      rd(`OFS_INTCTL, 32'h9);
      lvl(i[0], !i[0]);
    end
    wr(`OFS_INTCTL, 32'h0);
    u_core.set_pins(~upper_nibble_input_port);
    repeat (6) @(posedge ref_clk);
    lvl(1'b0, 1'b0);
    rd(`OFS_INTCTL, 32'h1);
    // context save on three accepts, then one return
    for (int k = 0; k < 3; k++) begin
      pcs[k] = pc_addr_t'($urandom);
      {w, s, b} = 24'($urandom);
      u_core.take(pcs[k], w, s, b);
      #1;
      check("return_addr", {12'h0, return_addr}, {12'h0, pcs[k]});
      check("shadow", {9'h0, shadow_bank, shadow_status, shadow_working},
            {9'h0, b, s, w});
      rd(`OFS_SHADOW, {8'h0, b, s, w});
      rd(`OFS_STACK, {6'h0, 5'(k + 1), pcs[k]});
    end
    u_core.pop();
    #1;
    check("return_addr", {12'h0, return_addr}, {12'h0, pcs[1]});
    // drain the stack; the last pop finds it empty and is ignored
    repeat (3) u_core.pop();
    #1;
    check("return_addr", {12'h0, return_addr}, 33'h0);
    rd(`OFS_STACK, 32'h0);
    repeat (4) @(posedge ref_clk);
    wrap_up();
  end
endmodule
`default_nettype wire
